/* File: dptr_pkg.sv */
// Summary of operation
// R1 - A 2 KB dual-ported RAM sits at the top of the Y data space; the code sets BASE_ADDR to 16'h0000.
// R2 - Processor and DMA ports are independent and may both access each cycle.
// R3 - The DMA controller stages outgoing and incoming peripheral data here.
// R4 - DMA traffic never steals cycles from processor data accesses.
// R5 - Same-cycle writes to one location: the processor write wins.
// R6 - The processor port is never stalled, whatever the DMA port does.
// R7 - A read colliding with the other port's write returns the old value.
`default_nettype none
package dptr_pkg;
  localparam int unsigned RAM_BYTES = 2048;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORDS = RAM_BYTES / (DATA_W / 8);
  localparam int unsigned ADDR_W = $clog2(WORDS);
  localparam int unsigned BE_W = DATA_W / 8;
  localparam logic [15:0] BASE_ADDR = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

  typedef struct packed {
    logic en;
    logic we;
    logic [BE_W-1:0] be;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dptr_req_t;
endpackage : dptr_pkg
`default_nettype wire

/* File: dptr_port_read.sv */
`timescale 1ns/1ps
`default_nettype none
module dptr_port_read #(
  parameter int unsigned DW = dptr_pkg::DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rd_i,
  input wire logic [DW-1:0] mem_word_i,
  output logic [DW-1:0] rdata_o,
  output logic rvalid_o
);
  // Read data is registered from the array before any same-cycle write lands.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= dptr_pkg::RDATA_RST;
    end else if (ce_i && rd_i) begin
      rdata_o <= mem_word_i; // R7
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_o <= 1'b0;
    end else if (ce_i) begin
      rvalid_o <= rd_i;
    end
  end
endmodule : dptr_port_read
`default_nettype wire

/* File: dptr_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module dptr_ram #(
  parameter int unsigned WORDS = dptr_pkg::WORDS,
  parameter int unsigned AW = dptr_pkg::ADDR_W,
  parameter int unsigned DW = dptr_pkg::DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire dptr_pkg::dptr_req_t cpu_req_i,
  output logic [DW-1:0] cpu_rdata_o,
  output logic cpu_rvalid_o,
  output logic cpu_stall_o,
  input wire dptr_pkg::dptr_req_t dma_req_i,
  output logic [DW-1:0] dma_rdata_o,
  output logic dma_rvalid_o,
  output logic dma_stall_o,
  output logic dma_lost_o
);
  logic [DW-1:0] mem [WORDS]; // R1
  logic [DW-1:0] next_cpu_word;
  logic [DW-1:0] next_dma_word;
  logic collide;
  logic cpu_wr;
  logic cpu_rd;
  logic dma_wr;
  logic dma_rd;
  logic [AW-1:0] cpu_addr;
  logic [AW-1:0] dma_addr;

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                          input logic [DW-1:0] nw,
                                          input logic [dptr_pkg::BE_W-1:0] be);
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < dptr_pkg::BE_W; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // The two ports collide when both write the same word this cycle.
  assign collide = cpu_req_i.en && cpu_req_i.we && dma_req_i.en && dma_req_i.we
                   && (cpu_req_i.addr == dma_req_i.addr);
  assign next_cpu_word = merge(mem[cpu_req_i.addr], cpu_req_i.wdata, cpu_req_i.be);
  assign next_dma_word = merge(mem[dma_req_i.addr], dma_req_i.wdata, dma_req_i.be);

  // Decoded request kinds and addresses for each port.
  assign cpu_wr = cpu_req_i.en && cpu_req_i.we;
  assign cpu_rd = cpu_req_i.en && !cpu_req_i.we;
  assign dma_wr = dma_req_i.en && dma_req_i.we;
  assign dma_rd = dma_req_i.en && !dma_req_i.we;
  assign cpu_addr = cpu_req_i.addr;
  assign dma_addr = dma_req_i.addr;

  // Neither port is ever held off; a DMA write that collides is dropped and flagged on dma_lost_o.
  assign cpu_stall_o = 1'b0; // R4 R6
  assign dma_stall_o = 1'b0; // R2
  assign dma_lost_o = ce_i && collide; // R5

  // A DMA write that collides with a processor write is skipped, so the processor write wins.
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (dma_req_i.en && dma_req_i.we && !collide) begin
        mem[dma_req_i.addr] <= next_dma_word; // R3 R5
      end
      if (cpu_req_i.en && cpu_req_i.we) begin
        mem[cpu_req_i.addr] <= next_cpu_word; // R5
      end
    end
  end

  dptr_port_read #(.DW(DW)) u_cpu_rd (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .rd_i(cpu_req_i.en && !cpu_req_i.we),
    .mem_word_i(mem[cpu_req_i.addr]),
    .rdata_o(cpu_rdata_o),
    .rvalid_o(cpu_rvalid_o)
  );

  dptr_port_read #(.DW(DW)) u_dma_rd (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .rd_i(dma_req_i.en && !dma_req_i.we),
    .mem_word_i(mem[dma_req_i.addr]),
    .rdata_o(dma_rdata_o),
    .rvalid_o(dma_rvalid_o)
  );

  property p_no_stall;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !cpu_stall_o;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("processor port stalled"); // R6

  property p_cpu_rd_lat;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && cpu_req_i.en && !cpu_req_i.we) |=> cpu_rvalid_o;
  endproperty
  a_cpu_rd_lat: assert property (p_cpu_rd_lat) else $error("cpu read not answered"); // R4

  property p_dma_rd_lat;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && dma_req_i.en && !dma_req_i.we) |=> dma_rvalid_o;
  endproperty
  a_dma_rd_lat: assert property (p_dma_rd_lat) else $error("dma read not answered"); // R2

  property p_cpu_wins;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && collide && (&cpu_req_i.be))
      |=> mem[$past(cpu_req_i.addr)] == $past(cpu_req_i.wdata);
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("cpu write lost collision"); // R5

  property p_dma_wr;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && dma_req_i.en && dma_req_i.we && !collide && (&dma_req_i.be)
       && !(cpu_req_i.en && cpu_req_i.we))
      |=> mem[$past(dma_req_i.addr)] == $past(dma_req_i.wdata);
  endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("dma write not stored"); // R3

  property p_old_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && cpu_req_i.en && !cpu_req_i.we && dma_req_i.en && dma_req_i.we
       && cpu_req_i.addr == dma_req_i.addr)
      |=> cpu_rdata_o == $past(mem[cpu_req_i.addr]);
  endproperty
  a_old_data: assert property (p_old_data) else $error("read saw new data"); // R7

  property p_cpu_rd_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && cpu_rd)
      |=> cpu_rdata_o == $past(mem[cpu_addr]);
  endproperty
  a_cpu_rd_data: assert property (p_cpu_rd_data) else $error("cpu read data wrong"); // R4

  property p_dma_rd_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && dma_rd)
      |=> dma_rdata_o == $past(mem[dma_addr]);
  endproperty
  a_dma_rd_data: assert property (p_dma_rd_data) else $error("dma read data wrong"); // R2

  property p_dma_old_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && dma_rd && cpu_wr && dma_addr == cpu_addr)
      |=> dma_rdata_o == $past(mem[dma_addr]);
  endproperty
  a_dma_old_data: assert property (p_dma_old_data) else $error("dma read saw new data"); // R7

  property p_cpu_rd_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !(ce_i && cpu_rd)
      |=> $stable(cpu_rdata_o);
  endproperty
  a_cpu_rd_hold: assert property (p_cpu_rd_hold) else $error("cpu read data moved"); // R2

  property p_dma_rd_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !(ce_i && dma_rd)
      |=> $stable(dma_rdata_o);
  endproperty
  a_dma_rd_hold: assert property (p_dma_rd_hold) else $error("dma read data moved"); // R2

  property p_cpu_rv_end;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && !cpu_rd)
      |=> !cpu_rvalid_o;
  endproperty
  a_cpu_rv_end: assert property (p_cpu_rv_end) else $error("cpu valid stuck high"); // R4

  property p_dma_rv_end;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && !dma_rd)
      |=> !dma_rvalid_o;
  endproperty
  a_dma_rv_end: assert property (p_dma_rv_end) else $error("dma valid stuck high"); // R2

  property p_cpu_wr_full;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && cpu_wr && (&cpu_req_i.be))
      |=> mem[$past(cpu_addr)] == $past(cpu_req_i.wdata);
  endproperty
  a_cpu_wr_full: assert property (p_cpu_wr_full) else $error("cpu write not stored"); // R4

  property p_keep_hi;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && collide && !cpu_req_i.be[1])
      |=> mem[$past(cpu_addr)][DW-1:8] == $past(mem[cpu_addr][DW-1:8]);
  endproperty
  a_keep_hi: assert property (p_keep_hi) else $error("dropped dma write hit byte 1"); // R5

  property p_keep_lo;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && collide && !cpu_req_i.be[0])
      |=> mem[$past(cpu_addr)][7:0] == $past(mem[cpu_addr][7:0]);
  endproperty
  a_keep_lo: assert property (p_keep_lo) else $error("dropped dma write hit byte 0"); // R5

  property p_ce_cpu_mem;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!ce_i && cpu_wr)
      |=> mem[$past(cpu_addr)] == $past(mem[cpu_addr]);
  endproperty
  a_ce_cpu_mem: assert property (p_ce_cpu_mem) else $error("cpu write while frozen"); // R1

  property p_ce_dma_mem;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!ce_i && dma_wr)
      |=> mem[$past(dma_addr)] == $past(mem[dma_addr]);
  endproperty
  a_ce_dma_mem: assert property (p_ce_dma_mem) else $error("dma write while frozen"); // R1

  c_collide: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ce_i && collide);
  c_both_rd: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && cpu_req_i.en && dma_req_i.en && !cpu_req_i.we && !dma_req_i.we);
  c_rw: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && cpu_req_i.en && !cpu_req_i.we && dma_req_i.en && dma_req_i.we);
  c_ce_low: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !ce_i && cpu_wr && dma_wr);
  c_part_clash: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && collide && !(&cpu_req_i.be));
endmodule : dptr_ram
`default_nettype wire

/* File: dptr_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dptr_dma_model (
  input wire logic clk_sys_i,
  input wire dptr_pkg::dptr_req_t cmd_i,
  output dptr_pkg::dptr_req_t req_o
);
  // Drives the DMA port at the falling edge; idle cycles show inverted stale fields.
  always @(negedge clk_sys_i) begin
    if (cmd_i.en) begin
      req_o <= cmd_i;
    end else begin
      req_o <= {1'b0, 1'b0, ~req_o.be, ~req_o.addr, ~req_o.wdata};
    end
  end
endmodule : dptr_dma_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch %0t got %h", $time, a); end end
module tb_top;
  localparam dptr_pkg::dptr_req_t IDL = '0;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  int fail_count = 0;
  int check_count = 0;
  dptr_pkg::dptr_req_t cpu, dcmd, dma;
  logic [15:0] cd, dd;
  logic cv, dv, cs, ds, lost;
  always #20 clk_sys_i = ~clk_sys_i;
  dptr_dma_model u_dma (.clk_sys_i(clk_sys_i), .cmd_i(dcmd), .req_o(dma));
  dptr_ram dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce), .cpu_req_i(cpu),
    .cpu_rdata_o(cd), .cpu_rvalid_o(cv), .cpu_stall_o(cs), .dma_req_i(dma),
    .dma_rdata_o(dd), .dma_rvalid_o(dv), .dma_stall_o(ds), .dma_lost_o(lost));
  function automatic dptr_pkg::dptr_req_t rq(logic e, logic w,
      logic [dptr_pkg::ADDR_W-1:0] a, logic [15:0] d);
    rq = {e, w, 2'h3, a, d};
  endfunction : rq
  task automatic cyc(dptr_pkg::dptr_req_t c, dptr_pkg::dptr_req_t d, logic l);
    dcmd = d;
    @(negedge clk_sys_i);
    cpu <= c;
    #1;
    `CHK(lost, l)
    `CHK({cs, ds}, 2'h0)
    @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task automatic t_both;
    cyc(rq(1'b1, 1'b1, 10'h3ff, 16'h1234), rq(1'b1, 1'b1, 10'h000, 16'habcd), 1'b0);
    cyc(rq(1'b1, 1'b0, 10'h000, 16'h0), rq(1'b1, 1'b0, 10'h3ff, 16'h0), 1'b0);
    `CHK({cv, dv, cd, dd}, {2'h3, 16'habcd, 16'h1234})
  endtask : t_both
  task automatic t_clash;
    cyc(rq(1'b1, 1'b1, 10'h005, 16'haaaa), rq(1'b1, 1'b1, 10'h005, 16'h5555), 1'b1);
    cyc(rq(1'b1, 1'b0, 10'h005, 16'h0), rq(1'b1, 1'b0, 10'h005, 16'h0), 1'b0);
    `CHK({cv, cd, dd}, {1'b1, 16'haaaa, 16'haaaa})
    cyc(IDL, IDL, 1'b0);
    `CHK({cv, dv}, 2'h0)
  endtask : t_clash
  task automatic t_rdw;
    cyc(rq(1'b1, 1'b1, 10'h007, 16'h1111), IDL, 1'b0);
    cyc(rq(1'b1, 1'b1, 10'h007, 16'h2222), rq(1'b1, 1'b0, 10'h007, 16'h0), 1'b0);
    `CHK({cv, dv, dd}, {2'h1, 16'h1111})
    cyc(rq(1'b1, 1'b0, 10'h007, 16'h0), rq(1'b1, 1'b1, 10'h007, 16'h3333), 1'b0);
    `CHK({cv, cd}, {1'b1, 16'h2222})
    cyc(rq(1'b1, 1'b0, 10'h007, 16'h0), IDL, 1'b0);
    `CHK(cd, 16'h3333)
  endtask : t_rdw
  task automatic t_freeze;
    cyc(rq(1'b1, 1'b1, 10'h020, 16'h0f0f), rq(1'b1, 1'b1, 10'h021, 16'hf0f0), 1'b0);
    cyc(rq(1'b1, 1'b0, 10'h020, 16'h0), rq(1'b1, 1'b0, 10'h021, 16'h0), 1'b0);
    @(negedge clk_sys_i);
    ce <= 1'b0;
    #1;
    cyc(rq(1'b1, 1'b1, 10'h020, 16'hffff), rq(1'b1, 1'b1, 10'h020, 16'h1111), 1'b0);
    `CHK({cv, dv, cd, dd}, {2'h3, 16'h0f0f, 16'hf0f0})
    cyc(IDL, IDL, 1'b0);
    @(negedge clk_sys_i);
    ce <= 1'b1;
    #1;
    cyc(rq(1'b1, 1'b0, 10'h021, 16'h0), rq(1'b1, 1'b0, 10'h020, 16'h0), 1'b0);
    `CHK({cv, dv, cd, dd}, {2'h3, 16'hf0f0, 16'h0f0f})
  endtask : t_freeze
  task automatic t_bytes;
    dptr_pkg::dptr_req_t pw;
    pw = rq(1'b1, 1'b1, 10'h030, 16'h1234);
    pw.be = 2'h1;
    cyc(rq(1'b1, 1'b1, 10'h030, 16'hffff), rq(1'b1, 1'b1, 10'h031, 16'h0000), 1'b0);
    cyc(pw, rq(1'b1, 1'b1, 10'h030, 16'h5555), 1'b1);
    pw.addr = 10'h031;
    pw.be = 2'h2;
    pw.wdata = 16'h9988;
    cyc(pw, rq(1'b1, 1'b1, 10'h031, 16'h5555), 1'b1);
    pw.be = 2'h1;
    pw.wdata = 16'h1177;
    cyc(IDL, pw, 1'b0);
    cyc(rq(1'b1, 1'b0, 10'h031, 16'h0), rq(1'b1, 1'b0, 10'h030, 16'h0), 1'b0);
    `CHK({cv, dv, cd, dd}, {2'h3, 16'h9977, 16'hff34})
  endtask : t_bytes
  task automatic t_reset;
    cyc(rq(1'b1, 1'b0, 10'h030, 16'h0), rq(1'b1, 1'b0, 10'h031, 16'h0), 1'b0);
    `CHK({cv, dv, cd, dd}, {2'h3, 16'hff34, 16'h9977})
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    cpu <= IDL;
    #1;
    dcmd = IDL;
    `CHK({cv, dv, cd, dd}, {2'h0, dptr_pkg::RDATA_RST, dptr_pkg::RDATA_RST})
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    #1;
    cyc(rq(1'b1, 1'b0, 10'h031, 16'h0), IDL, 1'b0);
    `CHK({cv, cd}, {1'b1, 16'h9977})
  endtask : t_reset
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    cpu = IDL;
    dcmd = IDL;
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    t_both();
    t_clash();
    t_rdw();
    t_freeze();
    t_bytes();
    t_reset();
    results();
  end
  initial begin
    #20000;
    fail_count++;
    results();
  end
endmodule : tb_top
`default_nettype wire
